// ### hw/css_pkg.sv
// config startup sequencer: shared constants, types and behaviour notes
// Notes on behaviour
// - done raised in selected phase, default four
// - done-pin wait: pin high, then one edge
// - done-pin wait delays done past its phase
// - io three-state hold released in selected phase
// - global write enable asserted in selected phase
// - block ram blocked until write enable phase
// - live reconfig suppresses global hold and set/reset
// - security levels gate readback and reconfiguration
// - frame checksum mismatch flags init and error
// - jtag disable blocks boundary scan after done
// - adc jtag access: enabled, disabled, status-only
// - config port select top, bottom, auto
// - adc safe mode during reconfiguration if enabled
// - startup clock source selectable: config, user, jtag
package css_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PHASE = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [2:0] PH_DONE = 3'h0;
  localparam logic [2:0] PH_KEEP = 3'h7;
  localparam int NUM_CLK = 3;

  typedef enum logic [1:0] {
    SEC_NONE = 2'b00, SEC_LEVEL1 = 2'b01, SEC_LEVEL2 = 2'b10
  } css_sec_e;
  typedef enum logic [1:0] {
    ADC_ENABLE = 2'b00, ADC_DISABLE = 2'b01, ADC_STATUS = 2'b10
  } css_adc_e;
  typedef enum logic [1:0] {
    PORT_AUTO = 2'b00, PORT_TOP = 2'b01, PORT_BOTTOM = 2'b10
  } css_port_e;
  typedef enum logic [1:0] {
    CLK_CFG = 2'b00, CLK_USER = 2'b01, CLK_JTAG = 2'b10
  } css_clk_e;
  typedef enum logic [1:0] {
    ST_LOAD = 2'b00, ST_RUN = 2'b01, ST_DONE = 2'b10
  } css_state_e;

  typedef struct packed {
    css_clk_e sequencer_clock_select;
    logic adc_safe_mode_option;
    css_port_e config_port_select;
    css_adc_e adc_jtag_access_mode;
    css_sec_e security;
    logic jtag_disable;
    logic frame_checksum_option;
    logic live_reconfig_option;
    logic done_pin_wait_option;
  } css_ctrl_s;

  typedef struct packed {
    logic [2:0] global_write_enable_phase;
    logic [2:0] io_tristate_release_phase;
    logic [2:0] done_phase;
  } css_phase_s;

  typedef struct packed {
    logic frame_error;
    logic write_enabled;
    logic io_released;
    logic done;
    logic [2:0] phase;
    css_state_e state;
  } css_status_s;

  typedef struct packed {
    logic valid;
    logic is_checksum;
    logic [DATA_W-1:0] data;
  } css_word_s;

  localparam css_ctrl_s CTRL_RESET = '{
    sequencer_clock_select: CLK_CFG, adc_safe_mode_option: 1'b0,
    config_port_select: PORT_AUTO, adc_jtag_access_mode: ADC_ENABLE,
    security: SEC_NONE, jtag_disable: 1'b0, frame_checksum_option: 1'b0,
    live_reconfig_option: 1'b0, done_pin_wait_option: 1'b1};
  localparam css_phase_s PHASE_RESET = '{
    global_write_enable_phase: 3'h6, io_tristate_release_phase: 3'h5,
    done_phase: 3'h4};
endpackage

// ### hw/css_pin_sync.sv
// two-stage pin synchroniser with rising-edge pulse
`timescale 1ns/1ns
module css_pin_sync #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level,
  output logic [W-1:0] rise
);
  logic [W-1:0] meta;
  logic [W-1:0] last;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      meta <= '0;
      level <= '0;
      last <= '0;
    end else begin
      meta <= pin;
      level <= meta;
      last <= level;
    end
  end

  // edge taken from the settled stages only
  assign rise = level & ~last;
endmodule // css_pin_sync

// ### hw/css_frame_check.sv
// per-frame checksum checker for the incoming configuration stream
`timescale 1ns/1ns
module css_frame_check (
  input wire logic clock,
  input wire logic nrst,
  input wire css_pkg::css_word_s word,
  input wire logic check_en,
  input wire logic clear,
  output logic load,
  output logic error
);
  import css_pkg::*;
  logic [DATA_W-1:0] acc;
  logic mismatch;

  assign mismatch = word.valid && word.is_checksum && check_en &&
                    (word.data != acc);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      acc <= '0;
    end else if (clear || (word.valid && word.is_checksum)) begin
      acc <= '0;
    end else if (word.valid) begin
      acc <= acc ^ word.data;
    end
  end

  // set wins over clear; while an error stands nothing more is loaded
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      error <= 1'b0;
      load <= 1'b0;
    end else begin
      error <= mismatch || (error && !clear);
      load <= word.valid && !word.is_checksum && !error && !mismatch;
    end
  end
endmodule // css_frame_check

// ### hw/css_sequencer.sv
// config startup sequencer: phase counter, release events, options
`timescale 1ns/1ns
module css_sequencer (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [css_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [css_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [css_pkg::DATA_W-1:0] reg_rdata,
  input wire logic load_complete,
  input wire logic reconfig_req,
  input wire logic readback_req,
  input wire css_pkg::css_word_s frame_word,
  output logic frame_load,
  input wire logic [css_pkg::NUM_CLK-1:0] startup_clk_pins,
  input wire logic done_pin_i,
  output logic done_pin_o,
  output logic done_pin_oe,
  output logic init_pin_o,
  output logic init_pin_oe,
  output logic partial_config_error_out,
  output logic done_out,
  output logic io_tristate_hold,
  output logic global_write_enable,
  output logic bram_enable,
  output logic global_interconnect_hold,
  output logic global_set_reset,
  output logic readback_grant,
  output logic reconfig_grant,
  output logic user_boundary_scan_block_enable,
  output logic adc_jtag_enable,
  output logic adc_jtag_status_only,
  output logic config_port_top,
  output logic config_port_bottom,
  output logic adc_safe_mode
);
  import css_pkg::*;

  css_ctrl_s ctrl;
  css_phase_s phase_cfg;
  css_status_s status;
  css_state_e state;
  css_state_e next_state;
  logic [2:0] run_phase;
  logic [2:0] next_phase;
  logic [NUM_CLK-1:0] clk_level;
  logic [NUM_CLK-1:0] clk_rise;
  logic [1:0] done_level;
  logic done_pin_s;
  logic step;
  logic done_req;
  logic pipe_seen;
  logic enter_done;
  logic reconfigured;
  logic go_load;
  logic frame_error;

  // phase code 1..6 hits once the counter reaches it
  function automatic logic phase_hit(input logic [2:0] code,
                                     input logic [2:0] ph);
    phase_hit = (code != PH_DONE) && (code != PH_KEEP) && (ph >= code);
  endfunction

  // release on a phase edge, or on done entry for done-coded events
  function automatic logic release_now(input logic [2:0] code,
                                       input logic st,
                                       input logic [2:0] ph,
                                       input logic ent);
    release_now = (st && phase_hit(code, ph)) ||
                  (ent && code == PH_DONE);
  endfunction

  css_pin_sync #(.W(NUM_CLK)) u_clk_sync (
    .clock(clock),
    .nrst(nrst),
    .pin(startup_clk_pins),
    .level(clk_level),
    .rise(clk_rise)
  );

  css_pin_sync #(.W(1)) u_done_sync (
    .clock(clock),
    .nrst(nrst),
    .pin(done_pin_i),
    .level(done_level[0]),
    .rise(done_level[1])
  );
  assign done_pin_s = done_level[0];

  css_frame_check u_frame (
    .clock(clock),
    .nrst(nrst),
    .word(frame_word),
    .check_en(ctrl.frame_checksum_option),
    .clear(load_complete),
    .load(frame_load),
    .error(frame_error)
  );

  // startup edge from the selected source; an unused code stalls
  always_comb begin
    case (ctrl.sequencer_clock_select)
      CLK_CFG: step = clk_rise[0];
      CLK_USER: step = clk_rise[1];
      CLK_JTAG: step = clk_rise[2];
      default: step = 1'b0;
    endcase
  end

  assign next_phase = (run_phase == 3'h7) ? run_phase : run_phase + 3'h1;
  assign go_load = reconfig_req && ctrl.security != SEC_LEVEL2 &&
                   ctrl.security != 2'b11 && state == ST_DONE;

  always_comb begin
    next_state = state;
    enter_done = 1'b0;
    case (state)
      ST_LOAD: begin
        if (load_complete && !frame_error) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (step) begin
          if (ctrl.done_pin_wait_option) begin
            enter_done = pipe_seen;
          end else begin
            enter_done = phase_hit(phase_cfg.done_phase, next_phase);
          end
        end
        if (enter_done) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        if (go_load) begin
          next_state = ST_LOAD;
        end
      end
      default: next_state = ST_LOAD;
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state <= ST_LOAD;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      run_phase <= 3'h0;
    end else if (state != ST_RUN) begin
      run_phase <= 3'h0;
    end else if (step) begin
      run_phase <= next_phase;
    end
  end

  // pin released at the done phase, state waits for it and one more edge
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      done_req <= 1'b0;
      pipe_seen <= 1'b0;
    end else if (state != ST_RUN) begin
      done_req <= 1'b0;
      pipe_seen <= 1'b0;
    end else begin
      if (step && phase_hit(phase_cfg.done_phase, next_phase)) begin
        done_req <= 1'b1;
      end
      if (done_req && done_pin_s) begin
        pipe_seen <= 1'b1;
      end
    end
  end

  // other parties may hold the pin low; external source keeps clocking
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      done_out <= 1'b0;
      done_pin_oe <= 1'b1;
      done_pin_o <= 1'b0;
    end else begin
      done_out <= (next_state == ST_DONE);
      done_pin_oe <= !(done_req || next_state == ST_DONE);
      done_pin_o <= 1'b0;
    end
  end

  // release events; a full reload re-holds unless reconfig is live
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      io_tristate_hold <= 1'b1;
    end else if (go_load && !ctrl.live_reconfig_option) begin
      io_tristate_hold <= 1'b1;
    end else if (release_now(phase_cfg.io_tristate_release_phase,
                             state == ST_RUN && step, next_phase,
                             enter_done)) begin
      io_tristate_hold <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      global_write_enable <= 1'b0;
      bram_enable <= 1'b0;
    end else if (go_load && !ctrl.live_reconfig_option) begin
      global_write_enable <= 1'b0;
      bram_enable <= 1'b0;
    end else if (release_now(phase_cfg.global_write_enable_phase,
                             state == ST_RUN && step, next_phase,
                             enter_done)) begin
      global_write_enable <= 1'b1;
      bram_enable <= 1'b1;
    end
  end

  // holds during loading keep state still; live reconfig must not touch it
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      global_set_reset <= 1'b1;
      global_interconnect_hold <= 1'b1;
    end else begin
      global_set_reset <= (next_state == ST_LOAD) &&
                          !ctrl.live_reconfig_option;
      global_interconnect_hold <= (next_state == ST_LOAD ||
                                   io_tristate_hold) &&
                                  !ctrl.live_reconfig_option;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      reconfigured <= 1'b0;
    end else if (go_load) begin
      reconfigured <= 1'b1;
    end else if (state == ST_RUN) begin
      reconfigured <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      readback_grant <= 1'b0;
      reconfig_grant <= 1'b0;
    end else begin
      readback_grant <= readback_req && ctrl.security == SEC_NONE;
      reconfig_grant <= go_load;
    end
  end

  // init pin is open drain: low while a checksum error stands
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      init_pin_o <= 1'b0;
      init_pin_oe <= 1'b0;
      partial_config_error_out <= 1'b0;
    end else begin
      init_pin_o <= 1'b0;
      init_pin_oe <= frame_error;
      partial_config_error_out <= frame_error;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      user_boundary_scan_block_enable <= 1'b1;
      adc_jtag_enable <= 1'b1;
      adc_jtag_status_only <= 1'b0;
      config_port_top <= 1'b1;
      config_port_bottom <= 1'b0;
      adc_safe_mode <= 1'b0;
    end else begin
      user_boundary_scan_block_enable <= !(ctrl.jtag_disable && state == ST_DONE);
      adc_jtag_enable <= ctrl.adc_jtag_access_mode == ADC_ENABLE ||
                         ctrl.adc_jtag_access_mode == ADC_STATUS;
      adc_jtag_status_only <= ctrl.adc_jtag_access_mode == ADC_STATUS;
      // auto resolves to top; bottom only when asked for
      config_port_bottom <= ctrl.config_port_select == PORT_BOTTOM;
      config_port_top <= ctrl.config_port_select != PORT_BOTTOM;
      adc_safe_mode <= reconfigured && ctrl.adc_safe_mode_option &&
                       state != ST_DONE;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctrl <= CTRL_RESET;
      phase_cfg <= PHASE_RESET;
    end else if (reg_write) begin
      if (reg_addr == OFS_CTRL) begin
        ctrl <= css_ctrl_s'(reg_wdata[$bits(css_ctrl_s)-1:0]);
      end
      if (reg_addr == OFS_PHASE) begin
        phase_cfg <= css_phase_s'(reg_wdata[$bits(css_phase_s)-1:0]);
      end
    end
  end

  assign status = '{frame_error: frame_error,
                    write_enabled: global_write_enable,
                    io_released: !io_tristate_hold, done: done_out,
                    phase: run_phase, state: state};

  // read data stand one cycle only; unmapped reads return zero
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= '0;
    end else if (reg_read) begin
      case (reg_addr)
        OFS_CTRL: reg_rdata <= DATA_W'(ctrl);
        OFS_PHASE: reg_rdata <= DATA_W'(phase_cfg);
        OFS_STATUS: reg_rdata <= DATA_W'(status);
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  // run phase still holds the step that entered done
  property p_done_after_phase;
    $rose(done_out) |-> phase_hit(phase_cfg.done_phase, run_phase);
  endproperty
  a_done_after_phase: assert property (p_done_after_phase)
    else $error("done rose before its selected phase");

  property p_pipe_wait;
    $rose(done_out) && ctrl.done_pin_wait_option |-> $past(pipe_seen);
  endproperty
  a_pipe_wait: assert property (p_pipe_wait)
    else $error("done entered without seeing done pin high");

  property p_pipe_delays;
    $rose(done_req) && ctrl.done_pin_wait_option |-> !done_out;
  endproperty
  a_pipe_delays: assert property (p_pipe_delays)
    else $error("done raised at its phase despite pin wait");

  property p_io_keep;
    $fell(io_tristate_hold) |->
      $past(phase_cfg.io_tristate_release_phase) != PH_KEEP;
  endproperty
  a_io_keep: assert property (p_io_keep)
    else $error("io hold released with keep selected");

  property p_bram_gated;
    bram_enable == global_write_enable;
  endproperty
  a_bram_gated: assert property (p_bram_gated)
    else $error("block ram enable differs from write enable");

  property p_live_no_hold;
    ctrl.live_reconfig_option && $past(ctrl.live_reconfig_option) |->
      !global_set_reset && !global_interconnect_hold;
  endproperty
  a_live_no_hold: assert property (p_live_no_hold)
    else $error("global hold or set/reset during live reconfig");

  property p_security;
    ctrl.security != SEC_NONE |=> !readback_grant;
  endproperty
  a_security: assert property (p_security)
    else $error("readback granted under security");

  property p_frame_error;
    $rose(partial_config_error_out) |-> init_pin_oe;
  endproperty
  a_frame_error: assert property (p_frame_error)
    else $error("error port raised without init pin low");

  property p_jtag_block;
    ctrl.jtag_disable && state == ST_DONE |=> !user_boundary_scan_block_enable;
  endproperty
  a_jtag_block: assert property (p_jtag_block)
    else $error("boundary scan open after done with jtag disabled");

  property p_phase_hold;
    state == ST_RUN && next_state == ST_RUN && !step |=>
      run_phase == $past(run_phase);
  endproperty
  a_phase_hold: assert property (p_phase_hold)
    else $error("phase moved without a startup edge");

  property p_done_coded;
    $rose(done_out) && phase_cfg.global_write_enable_phase == PH_DONE &&
      $past(phase_cfg.global_write_enable_phase) == PH_DONE |->
      global_write_enable;
  endproperty
  a_done_coded: assert property (p_done_coded)
    else $error("done-coded write enable not released with done");

  c_done: cover property ($rose(done_out));
  c_frame_err: cover property ($rose(partial_config_error_out));
  c_reload: cover property (reconfig_grant ##1 state == ST_LOAD);
endmodule // css_sequencer

// ### verification/css_cfg_source.sv
// external configuration source model: startup clock pins and done pin
`timescale 1ns/1ns
module css_cfg_source (
  input wire logic clock,
  input wire logic done_pin_oe,
  input wire logic hold_done_low,
  output logic done_pin_i,
  output logic [css_pkg::NUM_CLK-1:0] startup_clk_pins
);
  import css_pkg::*;
  // pins stand low between steps, no free-running clock
  initial startup_clk_pins = '0;
  // open drain with pull-up: low while either party pulls
  assign done_pin_i = !(done_pin_oe || hold_done_low);
  // one startup edge; long low time covers the pin synchroniser
  task automatic step(input int pin);
    @(posedge clock);
    startup_clk_pins[pin] <= 1'b1;
    repeat (2) @(posedge clock);
    startup_clk_pins[pin] <= 1'b0;
    repeat (4) @(posedge clock);
    #1;
  endtask
endmodule // css_cfg_source

// ### verification/css_sequencer_tb.sv
// self-checking testbench for the config startup sequencer
`timescale 1ns/1ns
module css_sequencer_tb;
  import css_pkg::*;
  logic clock = 1'b0;
  logic nrst;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_write;
  logic reg_read;
  logic load_complete;
  logic reconfig_req;
  logic readback_req;
  logic hold_done_low;
  css_word_s frame_word;
  logic done_pin_o, init_pin_o;
  logic [31:0] reg_rdata;
  logic [31:0] s;
  logic [NUM_CLK-1:0] startup_clk_pins;
  logic done_pin_i, done_pin_oe, init_pin_oe, partial_config_error_out;
  logic frame_load, done_out, io_tristate_hold, global_write_enable;
  logic bram_enable, global_interconnect_hold, global_set_reset;
  logic readback_grant, reconfig_grant, user_boundary_scan_block_enable, adc_jtag_enable;
  logic adc_jtag_status_only, config_port_top, config_port_bottom;
  logic adc_safe_mode;
  int n_mismatch = 0;
  int tests_run = 0;

  always #2 clock = ~clock;

  css_sequencer i_css_sequencer (.clock(clock), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata),
    .load_complete(load_complete), .reconfig_req(reconfig_req),
    .readback_req(readback_req), .frame_word(frame_word),
    .frame_load(frame_load), .startup_clk_pins(startup_clk_pins),
    .done_pin_i(done_pin_i), .done_pin_o(done_pin_o),
    .done_pin_oe(done_pin_oe), .init_pin_o(init_pin_o),
    .init_pin_oe(init_pin_oe),
    .partial_config_error_out(partial_config_error_out),
    .done_out(done_out), .io_tristate_hold(io_tristate_hold),
    .global_write_enable(global_write_enable), .bram_enable(bram_enable),
    .global_interconnect_hold(global_interconnect_hold),
    .global_set_reset(global_set_reset), .readback_grant(readback_grant),
    .reconfig_grant(reconfig_grant), .user_boundary_scan_block_enable(user_boundary_scan_block_enable),
    .adc_jtag_enable(adc_jtag_enable),
    .adc_jtag_status_only(adc_jtag_status_only),
    .config_port_top(config_port_top),
    .config_port_bottom(config_port_bottom), .adc_safe_mode(adc_safe_mode));

  css_cfg_source i_css_cfg_source (.clock(clock), .done_pin_oe(done_pin_oe),
    .hold_done_low(hold_done_low), .done_pin_i(done_pin_i),
    .startup_clk_pins(startup_clk_pins));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %0h exp %0h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // every input idles here, mid-run resets included
  task automatic do_reset();
    nrst <= 1'b0;
    {reg_write, reg_read, load_complete, reconfig_req} <= 4'h0;
    {readback_req, hold_done_low} <= 2'h0;
    reg_addr <= 8'h00;
    reg_wdata <= 32'h0;
    frame_word <= '0;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // 0 load complete, 1 reconfig, 2 readback; grants are one-cycle pulses
  task automatic pulse(input int k);
    @(posedge clock);
    case (k)
      0: load_complete <= 1'b1;
      1: reconfig_req <= 1'b1;
      default: readback_req <= 1'b1;
    endcase
    @(posedge clock);
    {load_complete, reconfig_req, readback_req} <= 3'b000;
    #1;
  endtask

  task automatic settle();
    repeat (2) @(posedge clock);
    #1;
  endtask

  task automatic send(input logic [31:0] d, input logic ck);
    @(posedge clock);
    frame_word <= '{1'b1, ck, d};
    @(posedge clock);
    frame_word <= '{1'b0, 1'b0, 32'h0};
    #1;
  endtask

  task automatic t_reset();
    rd(OFS_CTRL, s);
    chk(s, 32'h1);
    rd(OFS_PHASE, s);
    chk(s, 32'h1AC);
    rd(8'h40, s);
    chk(s, 32'h0);
    chk(io_tristate_hold, 1'b1);
    chk(bram_enable, 1'b0);
    chk(global_set_reset, 1'b1);
    chk(config_port_top, 1'b1);
  endtask

  task automatic t_default_startup();
    hold_done_low <= 1'b1;
    pulse(0);
    repeat (3) i_css_cfg_source.step(0);
    chk(done_pin_oe, 1'b1);
    i_css_cfg_source.step(0);
    chk(done_pin_oe, 1'b0);
    chk(done_pin_o, 1'b0);
    chk(done_out, 1'b0);
    i_css_cfg_source.step(0);
    chk(io_tristate_hold, 1'b0);
    chk(bram_enable, 1'b0);
    // other device lets done go high; no done until the next startup edge
    hold_done_low <= 1'b0;
    settle();
    settle();
    chk(done_out, 1'b0);
    i_css_cfg_source.step(0);
    chk(done_out, 1'b1);
    chk(global_write_enable, 1'b1);
    chk(bram_enable, 1'b1);
    rd(OFS_STATUS, s);
    chk(s[8:0], 9'h0E2);
  endtask

  task automatic t_keep_done();
    do_reset();
    wr(OFS_CTRL, 32'h1008);
    // done at two, io kept, write enable on done entry
    wr(OFS_PHASE, 32'h03A);
    pulse(0);
    i_css_cfg_source.step(0);
    rd(OFS_STATUS, s);
    chk(s[4:2], 3'h0);
    i_css_cfg_source.step(2);
    rd(OFS_STATUS, s);
    chk(s[4:2], 3'h1);
    chk(user_boundary_scan_block_enable, 1'b1);
    i_css_cfg_source.step(2);
    chk(done_out, 1'b1);
    chk(global_write_enable, 1'b1);
    chk(user_boundary_scan_block_enable, 1'b0);
    repeat (3) i_css_cfg_source.step(2);
    chk(io_tristate_hold, 1'b1);
  endtask

  // runs from the done state left by t_keep_done
  task automatic t_security();
    for (int i = 0; i < 3; i++) begin
      wr(OFS_CTRL, 32'h400 | (i << 4));
      pulse(2);
      chk(readback_grant, i == 0);
    end
    pulse(1);
    chk(reconfig_grant, 1'b0);
    wr(OFS_CTRL, 32'h410);
    pulse(1);
    chk(reconfig_grant, 1'b1);
    settle();
    chk(adc_safe_mode, 1'b1);
  endtask

  task automatic t_options();
    do_reset();
    wr(OFS_CTRL, 32'h3);
    settle();
    chk(global_set_reset, 1'b0);
    chk(global_interconnect_hold, 1'b0);
    for (int i = 0; i < 3; i++) begin
      wr(OFS_CTRL, (i << 6) | (i << 8));
      settle();
      chk(adc_jtag_enable, i != 1);
      chk(adc_jtag_status_only, i == 2);
      chk(config_port_top, i != 2);
      chk(config_port_bottom, i == 2);
    end
  endtask

  task automatic t_checksum();
    do_reset();
    wr(OFS_CTRL, 32'h5);
    send(32'h12345678, 1'b0);
    chk(frame_load, 1'b1);
    send(32'h0F0F0F0F, 1'b0);
    send(32'h1D3B5977, 1'b1);
    settle();
    chk(partial_config_error_out, 1'b0);
    send(32'hA5A5A5A5, 1'b0);
    send(32'hA5A5A5A4, 1'b1);
    settle();
    chk(partial_config_error_out, 1'b1);
    chk(init_pin_oe, 1'b1);
    chk(init_pin_o, 1'b0);
    send(32'h00000001, 1'b0);
    chk(frame_load, 1'b0);
  endtask

  // generous bound: the whole run is about two hundred cycles
  initial begin
    #200000;
    n_mismatch++;
    conclude();
  end

  initial begin
    do_reset();
    t_reset();
    t_default_startup();
    t_keep_done();
    t_security();
    t_options();
    t_checksum();
    conclude();
  end
endmodule // css_sequencer_tb
